// file: hdl/crs_pkg.sv
`default_nettype none
package crs_pkg;
   // Condition flag field positions
   localparam int IME_BIT   = 0;
   localparam int ZERO_BIT  = 1;
   localparam int CARRY_BIT = 2;
   localparam int SUPER_BIT = 3;
   localparam int BANK_BIT  = 4;
   // Software-writable flag bits (interrupt enable, zero, carry, bank select)
   localparam logic [7:0] FLAGS_WR_MASK = 8'h17;
   // Reset values
   localparam logic [7:0] FLAGS_RST = 8'h02;
   localparam logic [7:0] ACC_RST   = 8'h00;
   localparam logic [7:0] IDX_RST   = 8'h00;
   localparam logic [7:0] SP_RST    = 8'h00;
   localparam logic [7:0] PCH_RST   = 8'h00;
   localparam logic [7:0] PCL_RST   = 8'h00;
   // Register select codes on the plain port
   localparam logic [2:0] SEL_FLAGS = 3'h0;
   localparam logic [2:0] SEL_ACC   = 3'h1;
   localparam logic [2:0] SEL_IDX   = 3'h2;
   localparam logic [2:0] SEL_SP    = 3'h3;
   localparam logic [2:0] SEL_PCH   = 3'h4;
   localparam logic [2:0] SEL_PCL   = 3'h5;
   // Flag logical operations
   typedef enum logic [1:0] {
      FOP_AND = 2'b00,
      FOP_OR  = 2'b01,
      FOP_XOR = 2'b10,
      FOP_MOV = 2'b11
   } crs_fop_t;
endpackage
`default_nettype wire

// file: hdl/crs_register_set.sv
// Overview of operation
// - Flags change through the logical flag-operation port and the zero, carry and supervisor write inputs.
// - Accumulator is 8 bits, loaded with each source-mode instruction result.
// - Index register is 8 bits and drives the indexed-mode offset output.
// - Stack pointer is 8 bits, holding the current top-of-stack address.
// - High program counter byte holds program counter bits 15 to 8.
// - Low program counter byte holds program counter bits 7 to 0.
// - Flags carry zero in bit 1, carry in bit 2, supervisor in bit 3.
// - Flag bit 0 is the master interrupt enable gating all interrupts.
// - Supervisor bit is read-only to code; only the core changes it.
// - Zero and carry update from ALU results per instruction flag enables.
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module crs_register_set (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       acc_we,
   input  wire logic [7:0] acc_wdata,
   input  wire logic       idx_we,
   input  wire logic [7:0] idx_wdata,
   input  wire logic       sp_we,
   input  wire logic [7:0] sp_wdata,
   input  wire logic       pc_we,
   input  wire logic [15:0] pc_wdata,
   input  wire logic       flag_op_we,
   input  wire logic [1:0] flag_op,
   input  wire logic [7:0] flag_op_imm,
   input  wire logic       zero_we,
   input  wire logic       zero_in,
   input  wire logic       carry_we,
   input  wire logic       carry_in,
   input  wire logic       super_we,
   input  wire logic       super_in,
   input  wire logic       rd_stb,
   input  wire logic [2:0] rd_sel,
   output logic [7:0]      rd_data,
   output logic [7:0]      accumulator_reg,
   output logic [7:0]      index_offset,
   output logic [7:0]      stack_top_pointer,
   output logic [15:0]     program_counter,
   output logic [7:0]      condition_flags,
   output logic            zero_flag,
   output logic            carry_flag,
   output logic            supervisor_state,
   output logic            io_bank_select,
   output logic            interrupt_master_enable
);

   logic [7:0]  flags_r;
   logic [7:0]  flags_nxt;
   logic [7:0]  acc_r;
   logic [7:0]  idx_r;
   logic [7:0]  sp_r;
   logic [7:0]  pch_r;
   logic [7:0]  pcl_r;
   logic [7:0]  fop_res;
   logic [7:0]  rd_data_r;
   crs_pkg::crs_fop_t fop;

   assign fop = crs_pkg::crs_fop_t'(flag_op);

   always_comb begin
      case (fop)
         crs_pkg::FOP_AND: fop_res = flags_r & flag_op_imm;
         crs_pkg::FOP_OR:  fop_res = flags_r | flag_op_imm;
         crs_pkg::FOP_XOR: fop_res = flags_r ^ flag_op_imm;
         crs_pkg::FOP_MOV: fop_res = flag_op_imm;
         default:          fop_res = flags_r;
      endcase
   end

   always_comb begin
      flags_nxt = flags_r;
      if (zero_we) begin
         flags_nxt[crs_pkg::ZERO_BIT] = zero_in;
      end
      if (carry_we) begin
         flags_nxt[crs_pkg::CARRY_BIT] = carry_in;
      end
      if (flag_op_we) begin
         flags_nxt = (fop_res & crs_pkg::FLAGS_WR_MASK) |
                     (flags_r & ~crs_pkg::FLAGS_WR_MASK);
      end
      if (super_we) begin
         flags_nxt[crs_pkg::SUPER_BIT] = super_in;
      end
      flags_nxt[7:5] = 3'h0;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         flags_r <= crs_pkg::FLAGS_RST;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         acc_r <= crs_pkg::ACC_RST;
      end else if (acc_we) begin
         acc_r <= acc_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         idx_r <= crs_pkg::IDX_RST;
      end else if (idx_we) begin
         idx_r <= idx_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         sp_r <= crs_pkg::SP_RST;
      end else if (sp_we) begin
         sp_r <= sp_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         pch_r <= crs_pkg::PCH_RST;
         pcl_r <= crs_pkg::PCL_RST;
      end else if (pc_we) begin
         pch_r <= pc_wdata[15:8];
         pcl_r <= pc_wdata[7:0];
      end
   end

   // Registered read port
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rd_data_r <= 8'h00;
      end else if (rd_stb) begin
         case (rd_sel)
            crs_pkg::SEL_FLAGS: rd_data_r <= flags_r;
            crs_pkg::SEL_ACC:   rd_data_r <= acc_r;
            crs_pkg::SEL_IDX:   rd_data_r <= idx_r;
            crs_pkg::SEL_SP:    rd_data_r <= sp_r;
            crs_pkg::SEL_PCH:   rd_data_r <= pch_r;
            crs_pkg::SEL_PCL:   rd_data_r <= pcl_r;
            default:            rd_data_r <= 8'h00;
         endcase
      end
   end

   assign rd_data                 = rd_data_r;
   assign accumulator_reg         = acc_r;
   assign index_offset            = idx_r;
   assign stack_top_pointer       = sp_r;
   assign program_counter         = {pch_r, pcl_r};
   assign condition_flags         = flags_r;
   assign zero_flag               = flags_r[crs_pkg::ZERO_BIT];
   assign carry_flag              = flags_r[crs_pkg::CARRY_BIT];
   assign supervisor_state        = flags_r[crs_pkg::SUPER_BIT];
   assign io_bank_select          = flags_r[crs_pkg::BANK_BIT];
   assign interrupt_master_enable = flags_r[crs_pkg::IME_BIT];

endmodule // crs_register_set
`default_nettype wire

// file: tb/crs_register_set_checker.sv
`timescale 1ns/100ps
`default_nettype none
module crs_register_set_checker (
   input wire logic core_clk, rst, acc_we, idx_we, sp_we, pc_we, flag_op_we,
   input wire logic zero_we, carry_we, super_we, zero_flag, carry_flag,
   input wire logic supervisor_state, interrupt_master_enable,
   input wire logic [7:0] acc_wdata, idx_wdata, sp_wdata, accumulator_reg,
   input wire logic [7:0] index_offset, stack_top_pointer, condition_flags,
   input wire logic [15:0] pc_wdata, program_counter
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   AST_ACC: assert property (acc_we |=> accumulator_reg == $past(acc_wdata))
      else $error("acc load");
   AST_IDX: assert property (idx_we |=> index_offset == $past(idx_wdata))
      else $error("idx load");
   AST_SP: assert property (sp_we |=> stack_top_pointer == $past(sp_wdata))
      else $error("sp load");
   AST_PC: assert property (pc_we |=> program_counter == $past(pc_wdata))
      else $error("pc load");
   AST_MIR: assert property (condition_flags[3:1] == {supervisor_state, carry_flag, zero_flag})
      else $error("flag bits");
   AST_IME: assert property (condition_flags[0] == interrupt_master_enable)
      else $error("ime bit");
   AST_SUP: assert property (!super_we |=> $stable(supervisor_state))
      else $error("super moved");
   AST_HOLD: assert property (!(flag_op_we || zero_we || carry_we || super_we) |=> $stable(condition_flags))
      else $error("flags moved");
   AST_RST: assert property ($fell(rst) |-> condition_flags == 8'h02 && program_counter == 16'h0)
      else $error("reset value");
endmodule // crs_register_set_checker
`default_nettype wire

// file: tb/crs_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module crs_core_model (
   input  wire logic core_clk,
   output logic      zero_we, zero_in, carry_we, carry_in, super_we, super_in
);
   initial {zero_we, zero_in, carry_we, carry_in, super_we, super_in} = 6'h0;
   task automatic step(input logic zw, z, cw, c, sw, s);
      @(posedge core_clk);
      {zero_we, zero_in, carry_we, carry_in, super_we, super_in} <= {zw, z, cw, c, sw, s};
      @(posedge core_clk);
      {zero_we, zero_in, carry_we, carry_in, super_we, super_in} <= {1'b0, ~z, 1'b0, ~c, 1'b0, ~s};
   endtask
endmodule // crs_core_model
`default_nettype wire

// file: tb/crs_register_set_test.sv
`timescale 1ns/100ps
`default_nettype none
module crs_register_set_test;
   logic core_clk, rst, acc_we, idx_we, sp_we, pc_we, flag_op_we, rd_stb, zero_we, zero_in;
   logic carry_we, carry_in, super_we, super_in, zero_flag, carry_flag, supervisor_state;
   logic io_bank_select, interrupt_master_enable;
   logic [7:0] acc_wdata, idx_wdata, sp_wdata, flag_op_imm, rd_data, accumulator_reg;
   logic [7:0] index_offset, stack_top_pointer, condition_flags;
   logic [15:0] pc_wdata, program_counter;
   logic [1:0] flag_op;
   logic [2:0] rd_sel;
   int err_count = 0, cmp_count = 0;
   crs_register_set i_dut (.*);
   crs_core_model i_core (.*);
   task automatic chk(input logic [15:0] g, e);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("BAD %0t %h %h", $time, g, e);
      end
   endtask
   task automatic rd(input logic [2:0] s, input logic [7:0] e);
      @(posedge core_clk) {rd_stb, rd_sel} <= {1'b1, s};
      @(posedge core_clk) rd_stb <= 1'b0;
      #1 chk(rd_data, e);
   endtask
   task automatic fop(input logic [1:0] op, input logic [7:0] imm, e);
      @(posedge core_clk) {flag_op_we, flag_op, flag_op_imm} <= {1'b1, op, imm};
      @(posedge core_clk) flag_op_we <= 1'b0;
      #1 chk(condition_flags, e);
   endtask
   task automatic t_regs;
      @(posedge core_clk) {acc_we, idx_we, sp_we, pc_we} <= 4'hf;
      {acc_wdata, idx_wdata, sp_wdata, pc_wdata} <= {8'h5a, 8'ha5, 8'hc3, 16'h1f2e};
      @(posedge core_clk) {acc_we, idx_we, sp_we, pc_we} <= 4'h0;
      #1 chk(accumulator_reg, 8'h5a);
      chk(index_offset, 8'ha5);
      chk(stack_top_pointer, 8'hc3);
      rd(3'h4, 8'h1f);
      rd(3'h5, 8'h2e);
      rd(3'h1, 8'h5a);
      rd(3'h2, 8'ha5);
      rd(3'h3, 8'hc3);
      rd(3'h6, 8'h00);
      $display("t_regs done");
   endtask
   task automatic t_flags;
      fop(2'h3, 8'hff, 8'h17);
      chk(io_bank_select, 1'b1);
      fop(2'h0, 8'h05, 8'h05);
      chk(interrupt_master_enable, 1'b1);
      fop(2'h1, 8'h10, 8'h15);
      fop(2'h2, 8'h1f, 8'h02);
      i_core.step(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
      #1 chk(condition_flags, 8'h0a);
      chk(supervisor_state, 1'b1);
      fop(2'h3, 8'h00, 8'h08);
      i_core.step(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
      #1 chk(condition_flags, 8'h0c);
      chk(zero_flag, 1'b0);
      chk(carry_flag, 1'b1);
      $display("t_flags done");
   endtask
   task automatic t_reset;
      @(posedge core_clk) rst <= 1'b1;
      @(posedge core_clk) rst <= 1'b0;
      #1 chk(condition_flags, 8'h02);
      chk(accumulator_reg, 8'h00);
      chk(index_offset, 8'h00);
      chk(stack_top_pointer, 8'h00);
      chk(program_counter, 16'h0);
      $display("t_reset done");
   endtask
   task automatic summarize;
      $display("Counts %0d %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      #100000 err_count++;
      summarize();
   end
   initial begin
      {rst, acc_we, idx_we, sp_we, pc_we, flag_op_we, rd_stb} = 7'h40;
      {acc_wdata, idx_wdata, sp_wdata, flag_op_imm, pc_wdata, flag_op, rd_sel} = '0;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      #1 chk(condition_flags, 8'h02);
      chk(program_counter, 16'h0);
      chk(accumulator_reg, 8'h00);
      chk(index_offset, 8'h00);
      chk(stack_top_pointer, 8'h00);
      rd(3'h0, 8'h02);
      t_regs();
      t_flags();
      t_reset();
      summarize();
   end
endmodule // crs_register_set_test
bind crs_register_set crs_register_set_checker i_chk (.*);
`default_nettype wire
